/* File: common/aao_pkg.sv */
// Purpose: Constants and types for the add and AND execution datapath.
// Assumes: 14-bit instruction words, 8-bit data, 128-entry file register space.
// Notes:   Register map offsets are byte addresses on the APB slave.
// Operation
// [RULE_01] Add-literal adds the low literal byte to work, updates C, digit carry and Z.
// [RULE_02] And-literal ANDs work with the literal into work, changes only Z.
// [RULE_03] Add-file adds work and addressed file register, updates C, digit carry and Z.
// [RULE_04] And-file ANDs work with addressed file register, changes only Z.
// [RULE_05] Destination bit 0 writes work and leaves the file register unchanged.
// [RULE_06] Destination bit 1 writes the file register and leaves work unchanged.
// [RULE_07] An instruction cycle spans four oscillator periods.
// [RULE_08] One word, one cycle; carries out of bits 7 and 3; Z on zero.
package aao_pkg;

   localparam int unsigned AAO_DATA_W   = 8;
   localparam int unsigned AAO_INSN_W   = 14;
   localparam int unsigned AAO_FADDR_W  = 7;
   localparam int unsigned AAO_FILE_N   = 128;
   localparam int unsigned AAO_Q_N      = 4;

   // APB register byte offsets.
   localparam logic [7:0] AAO_OFS_INSN   = 8'h00;
   localparam logic [7:0] AAO_OFS_WORK   = 8'h04;
   localparam logic [7:0] AAO_OFS_STATUS = 8'h08;
   localparam logic [7:0] AAO_OFS_FDATA  = 8'h0C;
   localparam logic [7:0] AAO_OFS_FADDR  = 8'h10;
   localparam logic [7:0] AAO_OFS_COUNT  = 8'h14;

   // Status field positions.
   localparam int unsigned AAO_ST_C    = 0;
   localparam int unsigned AAO_ST_DIGIT = 1;
   localparam int unsigned AAO_ST_Z    = 2;
   localparam int unsigned AAO_ST_BUSY = 3;
   localparam int unsigned AAO_ST_ILL  = 4;

   // Opcode patterns on bits 13:8 and their masks.
   localparam logic [5:0] AAO_OP_ADDLIT   = 6'h3E;
   localparam logic [5:0] AAO_MSK_ADDLIT  = 6'h3E;
   localparam logic [5:0] AAO_OP_ANDLIT   = 6'h39;
   localparam logic [5:0] AAO_OP_ADDFILE  = 6'h07;
   localparam logic [5:0] AAO_OP_ANDFILE  = 6'h05;
   localparam logic [5:0] AAO_MSK_FULL    = 6'h3F;
   localparam int unsigned AAO_DEST_BIT   = 7;

   localparam logic [7:0]  AAO_WORK_RST   = 8'h00;
   localparam logic [1:0]  AAO_QPH_RST    = 2'h0;
   localparam logic [1:0]  AAO_QPH_LAST   = 2'h3;

   typedef enum logic [2:0] {
      AAO_OP_NONE,
      AAO_OP_ADD_LIT,
      AAO_OP_AND_LIT,
      AAO_OP_ADD_FILE,
      AAO_OP_AND_FILE
   } aao_op_e;

   typedef enum logic [0:0] {
      AAO_IDLE,
      AAO_EXEC
   } aao_state_e;

endpackage : aao_pkg

/* File: src/aao_alu.sv */
// Purpose: Combinational add and AND unit with flag generation.
// Assumes: Operands are 8 bits; flags are computed for every operation.
// Notes:   The caller decides which flags are kept.
`timescale 1ns/1ps
`default_nettype none
module aao_alu (
   input  wire logic [aao_pkg::AAO_DATA_W-1:0] op_a,
   input  wire logic [aao_pkg::AAO_DATA_W-1:0] op_b,
   input  wire logic                           do_and,
   output logic      [aao_pkg::AAO_DATA_W-1:0] result,
   output logic                                carry,
   output logic                                digit_carry_flag,
   output logic                                zero
);
   import aao_pkg::*;

   logic [AAO_DATA_W:0] sum;
   logic [4:0]          low_sum;

   always_comb begin
      sum              = {1'b0, op_a} + {1'b0, op_b};
      low_sum          = {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
      result           = do_and ? (op_a & op_b) : sum[AAO_DATA_W-1:0];
      carry            = sum[AAO_DATA_W];                 // see [RULE_08]
      digit_carry_flag = low_sum[4];                      // see [RULE_08]
      zero             = (result == 8'h00);               // see [RULE_08]
   end
endmodule : aao_alu
`default_nettype wire

/* File: src/aao_core.sv */
// Purpose: Executes the add and AND instructions on work and file registers.
// Assumes: APB slave, one clock; one instruction cycle is four pclk phases.
// Notes:   Software writes an instruction word; busy clears after the cycle.
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module aao_core (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             busy
);
   import aao_pkg::*;

   typedef struct packed {
      aao_state_e                state;
      logic [1:0]                qph;
      logic [AAO_INSN_W-1:0]     insn;
      logic [AAO_DATA_W-1:0]     work;
      logic                      c;
      logic                      digit;
      logic                      z;
      logic                      ill;
      logic [AAO_FADDR_W-1:0]    faddr;
      logic [15:0]               count;
      logic [31:0]               prdata;
      logic                      pready;
      logic                      pslverr;
   } aao_core_s;

   aao_core_s                  st_reg;
   aao_core_s                  st_next;
   logic [AAO_DATA_W-1:0]      file_mem [AAO_FILE_N];
   logic                       file_we;
   logic [AAO_FADDR_W-1:0]     file_wa;
   logic [AAO_DATA_W-1:0]      file_wd;
   aao_op_e                    op;
   logic [AAO_DATA_W-1:0]      op_b;
   logic [AAO_DATA_W-1:0]      alu_res;
   logic                       alu_c;
   logic                       alu_digit;
   logic                       alu_z;
   logic                       dest_file;
   logic                       acc;

   function automatic aao_op_e decode(input logic [AAO_INSN_W-1:0] w);
      if ((w[13:8] & AAO_MSK_ADDLIT) == AAO_OP_ADDLIT) begin
         return AAO_OP_ADD_LIT;
      end else if ((w[13:8] & AAO_MSK_FULL) == AAO_OP_ANDLIT) begin
         return AAO_OP_AND_LIT;
      end else if (w[13:8] == AAO_OP_ADDFILE) begin
         return AAO_OP_ADD_FILE;
      end else if (w[13:8] == AAO_OP_ANDFILE) begin
         return AAO_OP_AND_FILE;
      end else begin
         return AAO_OP_NONE;
      end
   endfunction : decode

   always_comb begin
      op        = decode(st_reg.insn);
      dest_file = st_reg.insn[AAO_DEST_BIT];
      if (op == AAO_OP_ADD_LIT || op == AAO_OP_AND_LIT) begin
         op_b = st_reg.insn[7:0];
      end else begin
         op_b = file_mem[st_reg.insn[6:0]];
      end
   end

   aao_alu u_alu (
      .op_a             (st_reg.work),
      .op_b             (op_b),
      .do_and           (op == AAO_OP_AND_LIT || op == AAO_OP_AND_FILE),
      .result           (alu_res),
      .carry            (alu_c),
      .digit_carry_flag (alu_digit),
      .zero             (alu_z)
   );

   always_comb begin
      st_next         = st_reg;
      file_we         = 1'b0;
      file_wa         = st_reg.insn[6:0];
      file_wd         = alu_res;
      acc             = psel && penable && !st_reg.pready;
      st_next.pready  = acc;
      st_next.pslverr = 1'b0;
      st_next.prdata  = 32'h0000_0000;

      // Execution: results commit on the last of four phases.
      if (st_reg.state == AAO_EXEC) begin
         st_next.qph = st_reg.qph + 2'h1;                 // see [RULE_07]
         if (st_reg.qph == AAO_QPH_LAST) begin
            st_next.state = AAO_IDLE;                     // see [RULE_08]
            st_next.count = st_reg.count + 16'h0001;
            case (op)
               AAO_OP_ADD_LIT: begin
                  st_next.work = alu_res;                 // see [RULE_01]
                  st_next.c    = alu_c;
                  st_next.digit = alu_digit;
                  st_next.z    = alu_z;
               end
               AAO_OP_AND_LIT: begin
                  st_next.work = alu_res;                 // see [RULE_02]
                  st_next.z    = alu_z;
               end
               AAO_OP_ADD_FILE, AAO_OP_AND_FILE: begin
                  st_next.z = alu_z;                      // see [RULE_04]
                  if (op == AAO_OP_ADD_FILE) begin
                     st_next.c  = alu_c;                  // see [RULE_03]
                     st_next.digit = alu_digit;
                  end
                  if (dest_file) begin
                     file_we = 1'b1;                      // see [RULE_06]
                  end else begin
                     st_next.work = alu_res;              // see [RULE_05]
                  end
               end
               default: begin
                  st_next.ill = 1'b1;
               end
            endcase
         end
      end

      if (acc && pwrite) begin
         if (paddr == AAO_OFS_INSN) begin
            if (st_reg.state == AAO_IDLE) begin
               st_next.insn  = pwdata[AAO_INSN_W-1:0];
               st_next.state = AAO_EXEC;
               st_next.qph   = AAO_QPH_RST;
               st_next.ill   = 1'b0;
            end else begin
               st_next.pslverr = 1'b1;
            end
         end else if (paddr == AAO_OFS_WORK) begin
            st_next.work = pwdata[7:0];
         end else if (paddr == AAO_OFS_STATUS) begin
            st_next.c  = pwdata[AAO_ST_C];
            st_next.digit = pwdata[AAO_ST_DIGIT];
            st_next.z  = pwdata[AAO_ST_Z];
         end else if (paddr == AAO_OFS_FDATA) begin
            if (!file_we) begin
               file_we = 1'b1;
               file_wa = st_reg.faddr;
               file_wd = pwdata[7:0];
            end else begin
               st_next.pslverr = 1'b1;
            end
         end else if (paddr == AAO_OFS_FADDR) begin
            st_next.faddr = pwdata[AAO_FADDR_W-1:0];
         end else if (paddr != AAO_OFS_COUNT) begin
            st_next.pslverr = 1'b1;
         end
      end else if (acc) begin
         if (paddr == AAO_OFS_INSN) begin
            st_next.prdata = {18'h0, st_reg.insn};
         end else if (paddr == AAO_OFS_WORK) begin
            st_next.prdata = {24'h0, st_reg.work};
         end else if (paddr == AAO_OFS_STATUS) begin
            st_next.prdata = {27'h0, st_reg.ill, st_reg.state == AAO_EXEC,
                              st_reg.z, st_reg.digit, st_reg.c};
         end else if (paddr == AAO_OFS_FDATA) begin
            st_next.prdata = {24'h0, file_mem[st_reg.faddr]};
         end else if (paddr == AAO_OFS_FADDR) begin
            st_next.prdata = {25'h0, st_reg.faddr};
         end else if (paddr == AAO_OFS_COUNT) begin
            st_next.prdata = {16'h0, st_reg.count};
         end else begin
            st_next.pslverr = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg       <= '0;
         st_reg.state <= AAO_IDLE;
         st_reg.work  <= AAO_WORK_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // File registers have no reset, as in a plain data memory.
   always_ff @(posedge pclk) begin
      if (file_we) begin
         file_mem[file_wa] <= file_wd;
      end
   end

   assign prdata  = st_reg.prdata;
   assign pready  = st_reg.pready;
   assign pslverr = st_reg.pslverr;
   assign busy    = (st_reg.state == AAO_EXEC);
endmodule : aao_core
`default_nettype wire

/* File: testbench/aao_core_chk.sv */
// Purpose: Concurrent checks on the APB side and the busy window of the core.
// Assumes: Sees only the top module ports; one clock domain.
// Notes:   Attached to every core instance by the bind below.
`timescale 1ns/1ps
`default_nettype none
module aao_core_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        busy
);
   import aao_pkg::*;

   logic acc;
   logic go;

   // An access phase waiting for its answer, and an instruction write among them.
   assign acc = psel && penable && !pready;
   assign go  = acc && pwrite && paddr == AAO_OFS_INSN;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   ready_wait_a: assert property (acc |=> pready)
      else $error("access phase not answered after one wait state");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("ready held for more than one cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   exec_cycle_a: assert property (go && !busy |=> busy [*4] ##1 !busy)
      else $error("instruction did not take exactly four cycles");
   busy_refuse_a: assert property (go && busy |=> pready && pslverr)
      else $error("instruction write while busy not refused");
   busy_cause_a: assert property ($rose(busy) |-> $past(go))
      else $error("busy rose without an instruction write");
   unmapped_read_a: assert property (acc && !pwrite && paddr > AAO_OFS_COUNT
      |=> pslverr && prdata == 32'h0)
      else $error("unmapped read not refused with zero data");
   mapped_read_a: assert property (acc && !pwrite && paddr <= AAO_OFS_COUNT
      && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped read refused");
endmodule : aao_core_chk

bind aao_core aao_core_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
`default_nettype wire

/* File: testbench/test_add_and_alu_ops.sv */
// Purpose: Self-checking bench for the add and AND core over APB.
// Assumes: Work and status flags are writable; count is read-only.
// Notes:   A monitor compares each answer with the oldest queued note.
`timescale 1ns/1ps
`default_nettype none
module test_add_and_alu_ops;
   import aao_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, busy;
   logic [7:0]  paddr, w, fv, b, res;
   logic [31:0] pwdata, prdata;
   logic [33:0] q[$];
   logic [33:0] e;
   logic [13:0] insn;
   logic [8:0]  sum;
   logic [6:0]  f;
   logic [15:0] cnt;
   logic        c, dig, z, d, lit, add;
   int          fail_count, checks, seed, n, i;

   aao_core u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .busy(busy));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   task automatic check(input logic [32:0] seen, input logic [32:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : tally_and_finish

   // One APB transfer; the note holds read flag, expected error and data.
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] dat,
                       input logic err, input logic [31:0] exp);
      int k;
      q.push_back({~wr, err, exp});
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= dat;
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 20 && pready !== 1'b1; k++) @(posedge pclk);
      if (k == 20) begin
         fail_count++;
         tally_and_finish();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : xfer

   always @(posedge pclk) begin
      if (pready === 1'b1) begin
         e = q.pop_front();
         check({pslverr, e[33] ? prdata : 32'h0}, e[32:0]);
      end
   end

   initial begin
      {psel, penable, pwrite, paddr, pwdata} = '0;
      presetn = 1'b0;
      fail_count = 0;
      checks = 0;
      seed = 83;
      cnt = 16'h0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, AAO_OFS_WORK, 32'h0, 1'b0, 32'h0);
      xfer(1'b0, AAO_OFS_STATUS, 32'h0, 1'b0, 32'h0);
      for (i = 0; i < 40; i++) begin
         w = 8'($random(seed));
         fv = 8'($random(seed));
         f = 7'($random(seed));
         insn = 14'($random(seed));
         {c, dig, z} = 3'($random(seed));
         if (i == 0) {w, insn[7:0], fv} = 24'hFF0101;
         lit = !i[1];
         add = !i[0];
         case (i % 4)
            0: insn[13:9] = 5'h1F;
            1: insn[13:8] = 6'h39;
            2: insn[13:8] = 6'h07;
            default: insn[13:8] = 6'h05;
         endcase
         // The file operand must be the register that the data window points at.
         if (!lit) insn[6:0] = f;
         xfer(1'b1, AAO_OFS_FADDR, 32'(f), 1'b0, 32'h0);
         xfer(1'b1, AAO_OFS_FDATA, 32'(fv), 1'b0, 32'h0);
         xfer(1'b1, AAO_OFS_WORK, 32'(w), 1'b0, 32'h0);
         xfer(1'b1, AAO_OFS_STATUS, {29'h0, z, dig, c}, 1'b0, 32'h0);
         xfer(1'b1, AAO_OFS_INSN, 32'(insn), 1'b0, 32'h0);
         xfer(1'b1, AAO_OFS_INSN, 32'h0, 1'b1, 32'h0);
         for (n = 0; n < 20 && busy !== 1'b0; n++) @(posedge pclk);
         if (n == 20) begin
            fail_count++;
            tally_and_finish();
         end
         b = lit ? insn[7:0] : fv;
         sum = {1'b0, w} + {1'b0, b};
         res = add ? sum[7:0] : w & b;
         if (add) begin
            c = sum[8];
            dig = ({1'b0, w[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
         end
         z = res == 8'h00;
         d = insn[AAO_DEST_BIT] && !lit;
         if (d) fv = res;
         else w = res;
         cnt++;
         xfer(1'b0, AAO_OFS_WORK, 32'h0, 1'b0, 32'(w));
         xfer(1'b0, AAO_OFS_STATUS, 32'h0, 1'b0, {29'h0, z, dig, c});
         xfer(1'b0, AAO_OFS_FDATA, 32'h0, 1'b0, 32'(fv));
      end
      // An opcode outside the four only marks itself illegal and still retires.
      xfer(1'b1, AAO_OFS_INSN, 32'h0, 1'b0, 32'h0);
      for (n = 0; n < 20 && busy !== 1'b0; n++) @(posedge pclk);
      if (n == 20) begin
         fail_count++;
         tally_and_finish();
      end
      cnt++;
      xfer(1'b0, AAO_OFS_WORK, 32'h0, 1'b0, 32'(w));
      xfer(1'b0, AAO_OFS_STATUS, 32'h0, 1'b0, {27'h0, 2'h2, z, dig, c});
      xfer(1'b0, AAO_OFS_COUNT, 32'h0, 1'b0, 32'(cnt));
      xfer(1'b1, AAO_OFS_COUNT, 32'hFFFF, 1'b0, 32'h0);
      xfer(1'b0, AAO_OFS_COUNT, 32'h0, 1'b0, 32'(cnt));
      xfer(1'b0, 8'h40, 32'h0, 1'b1, 32'h0);
      tally_and_finish();
   end
endmodule : test_add_and_alu_ops
`default_nettype wire
